// ==== src/tec_params.svh ====
`ifndef TEC_PARAMS_SVH
`define TEC_PARAMS_SVH

// Register byte offsets
`define TEC_OFF_MODE 12'h000
`define TEC_OFF_EDGE 12'h004
`define TEC_OFF_DATA 12'h008
`define TEC_OFF_CNT 12'h00C
`define TEC_OFF_TRIG 12'h010
`define TEC_OFF_STAT 12'h014
`define TEC_OFF_AUX 12'h018

// Mode control fields
`define TEC_MODE_CKS_HI 15
`define TEC_MODE_CKS_LO 14
`define TEC_MODE_CCS_HI 13
`define TEC_MODE_CCS_LO 12
`define TEC_MODE_MAS 11
`define TEC_MODE_MD_HI 4
`define TEC_MODE_MD_LO 1
`define TEC_MODE_MD0 0
`define TEC_MODE_WMASK 16'hFFDF

// Edge select, trigger and aux fields
`define TEC_EDGE_WMASK 8'h03
`define TEC_TRIG_START 0
`define TEC_TRIG_STOP 1
`define TEC_AUX_WMASK 32'h0000_000F

// Field codes
`define TEC_MD_EVENT 4'h3
`define TEC_MD_INTERVAL 4'h0
`define TEC_MD_CAPTURE 4'h2
`define TEC_MD_CNTCAP 4'hB
`define TEC_MD_CAP_ONE 4'h6
`define TEC_CCS_EDGE 2'h1

// Reset values
`define TEC_MODE_RST 16'h0000
`define TEC_EDGE_RST 8'h00
`define TEC_DATA_RST 32'h0000_0000

// Prescaler divide ratios
`define TEC_DIV0 16'h0001
`define TEC_DIV1 16'h0002
`define TEC_DIV2 16'h0004
`define TEC_DIV3 16'h0008

`endif

// ==== src/tec_pkg.sv ====
`default_nettype none
package tec_pkg;
  typedef enum logic [1:0] {
    TEC_EDGE_FALL,
    TEC_EDGE_RISE,
    TEC_EDGE_BOTH,
    TEC_EDGE_NONE
  } tec_edge_e;
  typedef logic [1:0] tec_sel_t;
endpackage : tec_pkg
`default_nettype wire

// ==== src/tec_event_counter.sv ====
// Behaviour
// - Mode field upper bits 0011 select event count mode.
// - Low mode bit enables start interrupt in interval, capture, count-capture.
// - Start trigger sets enable status and loads counter from data.
// - Enabled event mode, count clock select 01: each effective edge decrements counter, else holds.
// - Edge at zero reloads data and pulses interrupt.
// - Data zero reloads zero, interrupt every effective edge.
// - Stop trigger clears enable; counter holds.
// - Stopped channel ignores edges.
// - Start and stop trigger bits self-clear.
// - Start after stop reloads counter and resumes.
// - Start while counting forces immediate reload.
// - Data register writable anytime; reaches counter at start or reload.
// - Counter readable any time.
// - Edge select 00 falling, 01 rising, 10 both.
// - Count clock select 01 uses input edges as counter clock.
// - Operation clock select picks one of four prescaler outputs.
// - Mode register writes accepted only while channel disabled.
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "tec_params.svh"

module tec_event_counter
  import tec_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // Bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Event input and interrupt
  input wire logic count_input_pin,
  output logic channel_interrupt
);

  // Counter wider than the bus word could not be read back whole
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W must be 1..32");
  end

  // Bus address phase capture
  logic wr_pend_r;
  logic rd_pend_r;
  logic [11:0] addr_r;
  wire addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= addr_ok && !hwrite;
      if (addr_ok) begin
        addr_r <= haddr;
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  wire wr_mode = wr_pend_r && hit(addr_r, `TEC_OFF_MODE);
  wire wr_edge = wr_pend_r && hit(addr_r, `TEC_OFF_EDGE);
  wire wr_data = wr_pend_r && hit(addr_r, `TEC_OFF_DATA);
  wire wr_trig = wr_pend_r && hit(addr_r, `TEC_OFF_TRIG);
  wire wr_aux = wr_pend_r && hit(addr_r, `TEC_OFF_AUX);

  // Registers
  logic [15:0] mode_r;
  logic [7:0] edge_r;
  logic [CNT_W-1:0] data_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [3:0] aux_r;
  logic en_r;
  logic irq_r;

  // Trigger bits never store: they act in the write cycle, read as zero
  wire start_trig = wr_trig && hwdata[`TEC_TRIG_START];
  wire stop_trig = wr_trig && hwdata[`TEC_TRIG_STOP];

  wire [3:0] md_hi = mode_r[`TEC_MODE_MD_HI:`TEC_MODE_MD_LO];
  wire md0 = mode_r[`TEC_MODE_MD0];
  tec_sel_t cks;
  tec_sel_t ccs;
  assign cks = mode_r[`TEC_MODE_CKS_HI:`TEC_MODE_CKS_LO];
  assign ccs = mode_r[`TEC_MODE_CCS_HI:`TEC_MODE_CCS_LO];
  wire ev_mode = (md_hi == `TEC_MD_EVENT);
  wire start_irq_mode = (md_hi == `TEC_MD_INTERVAL) || (md_hi == `TEC_MD_CAPTURE)
                        || (md_hi == `TEC_MD_CNTCAP);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= `TEC_MODE_RST;
      edge_r <= `TEC_EDGE_RST;
      data_r <= '0;
      aux_r <= 4'h0;
    end else begin
      if (wr_mode && !en_r) begin
        mode_r <= hwdata[15:0] & `TEC_MODE_WMASK;
      end
      if (wr_edge) begin
        edge_r <= hwdata[7:0] & `TEC_EDGE_WMASK;
      end
      if (wr_data) begin
        data_r <= hwdata[CNT_W-1:0];
      end
      if (wr_aux) begin
        aux_r <= hwdata[3:0];
      end
    end
  end

  // Prescaler: four divided enables, one chosen as operation clock
  logic [15:0] pre_r;
  logic [3:0] ck_tick;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 16'h0000;
    end else begin
      pre_r <= pre_r + 16'h0001;
    end
  end
  localparam logic [15:0] DIVS [4] = '{`TEC_DIV0, `TEC_DIV1, `TEC_DIV2, `TEC_DIV3};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ck
      assign ck_tick[gi] = ((pre_r & (DIVS[gi] - 16'h0001)) == 16'h0000);
    end
  endgenerate
  wire op_tick = ck_tick[cks];

  // Input synchroniser and edge detection
  logic [2:0] pin_sync_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync_r <= 3'b000;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], count_input_pin};
    end
  end
  wire rise = pin_sync_r[1] && !pin_sync_r[2];
  wire fall = !pin_sync_r[1] && pin_sync_r[2];
  tec_edge_e esel;
  assign esel = tec_edge_e'(edge_r[1:0]);
  logic eff_edge;
  always_comb begin
    unique case (esel)
      TEC_EDGE_FALL: eff_edge = fall;
      TEC_EDGE_RISE: eff_edge = rise;
      TEC_EDGE_BOTH: eff_edge = rise || fall;
      TEC_EDGE_NONE: eff_edge = 1'b0;
    endcase
  end

  // Count clock: input edge or prescaled operation clock
  wire cnt_tick = (ccs == `TEC_CCS_EDGE) ? eff_edge : op_tick;
  // Stop and edge in one cycle: the stop wins, so a stopped count never moves
  wire do_count = en_r && ev_mode && cnt_tick && !start_trig && !stop_trig;
  wire at_zero = (cnt_r == '0);
  wire zero_hit = do_count && at_zero;
  wire start_irq = start_trig && start_irq_mode && md0;

  always_comb begin
    cnt_nxt = cnt_r;
    if (start_trig) begin
      cnt_nxt = data_r;
    end else if (do_count) begin
      cnt_nxt = at_zero ? data_r : cnt_r - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r <= 1'b0;
      cnt_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (start_trig) begin
        en_r <= 1'b1;
      end else if (stop_trig) begin
        en_r <= 1'b0;
      end
      cnt_r <= cnt_nxt;
      irq_r <= zero_hit || start_irq;
    end
  end
  assign channel_interrupt = irq_r;

  // Read mux; counter readable without side effects
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit(addr_r, `TEC_OFF_MODE)) rd_val = {16'h0000, mode_r};
    if (hit(addr_r, `TEC_OFF_EDGE)) rd_val = {24'h00_0000, edge_r};
    if (hit(addr_r, `TEC_OFF_DATA)) rd_val = 32'(data_r);
    if (hit(addr_r, `TEC_OFF_CNT)) rd_val = 32'(cnt_r);
    if (hit(addr_r, `TEC_OFF_STAT)) rd_val = {31'h0000_0000, en_r};
    if (hit(addr_r, `TEC_OFF_AUX)) rd_val = {28'h000_0000, aux_r} & `TEC_AUX_WMASK;
  end
  assign hrdata = rd_pend_r ? rd_val : 32'h0000_0000;
  wire rd_trig = rd_pend_r && hit(addr_r, `TEC_OFF_TRIG);

  // Checks
  property p_start_load;
    @(posedge hclk) disable iff (!hresetn)
      start_trig |=> (en_r && cnt_r == $past(data_r));
  endproperty
  a_start_load: assert property (p_start_load) else $error("start did not load");

  property p_stop;
    @(posedge hclk) disable iff (!hresetn)
      (stop_trig && !start_trig) |=> (!en_r && cnt_r == $past(cnt_r));
  endproperty
  a_stop: assert property (p_stop) else $error("stop failed");

  property p_idle_hold;
    @(posedge hclk) disable iff (!hresetn)
      (!en_r && !start_trig) |=> cnt_r == $past(cnt_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("stopped counter moved");

  property p_dec;
    @(posedge hclk) disable iff (!hresetn)
      (do_count && !at_zero) |=> (cnt_r == $past(cnt_r) - 1'b1) && !channel_interrupt;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");

  property p_reload;
    @(posedge hclk) disable iff (!hresetn)
      (do_count && at_zero) |=> (channel_interrupt && cnt_r == $past(data_r));
  endproperty
  a_reload: assert property (p_reload) else $error("zero reload wrong");

  property p_zero_data;
    @(posedge hclk) disable iff (!hresetn)
      (do_count && data_r == '0 && at_zero) |=> ##0 channel_interrupt ##0 at_zero;
  endproperty
  a_zero_data: assert property (p_zero_data) else $error("zero data irq missing");

  property p_mode_lock;
    @(posedge hclk) disable iff (!hresetn)
      (wr_mode && en_r) |=> mode_r == $past(mode_r);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("mode changed while on");

  property p_irq_pulse;
    @(posedge hclk) disable iff (!hresetn)
      (channel_interrupt && !cnt_tick && !start_trig) |=> !channel_interrupt;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq stretched");

  property p_edge_none;
    @(posedge hclk) disable iff (!hresetn)
      (esel == TEC_EDGE_NONE) |-> !eff_edge;
  endproperty
  a_edge_none: assert property (p_edge_none) else $error("code 11 saw edge");

  // Start interrupt, mode gating, count clock and input timing
  property p_start_irq;
    @(posedge hclk) disable iff (!hresetn)
      start_irq |=> channel_interrupt;
  endproperty
  a_start_irq: assert property (p_start_irq) else $error("start irq missing");

  property p_start_quiet;
    @(posedge hclk) disable iff (!hresetn)
      (start_trig && !(start_irq_mode && md0)) |=> !channel_interrupt;
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("start irq unexpected");

  property p_ev_only;
    @(posedge hclk) disable iff (!hresetn)
      (!ev_mode && !start_trig) |=> cnt_r == $past(cnt_r);
  endproperty
  a_ev_only: assert property (p_ev_only) else $error("count outside event mode");

  property p_edge_clock;
    @(posedge hclk) disable iff (!hresetn)
      (ccs == `TEC_CCS_EDGE && !eff_edge && !start_trig) |=> cnt_r == $past(cnt_r);
  endproperty
  a_edge_clock: assert property (p_edge_clock) else $error("count without edge");

  property p_fall_edge;
    @(posedge hclk) disable iff (!hresetn)
      (esel == TEC_EDGE_FALL && eff_edge) |-> !pin_sync_r[1] && $past(pin_sync_r[1]);
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("false falling edge");

  property p_rise_edge;
    @(posedge hclk) disable iff (!hresetn)
      (esel == TEC_EDGE_RISE && eff_edge) |-> pin_sync_r[1] && !$past(pin_sync_r[1]);
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("false rising edge");

  property p_prescale;
    @(posedge hclk) disable iff (!hresetn)
      (cks == 2'b11 && op_tick) |-> pre_r[2:0] == 3'h0;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler tick off");

  property p_trig_zero;
    @(posedge hclk) disable iff (!hresetn)
      rd_trig |-> hrdata == 32'h0000_0000;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("trigger bits read back");

  property p_irq_cause;
    @(posedge hclk) disable iff (!hresetn)
      channel_interrupt |-> $past(zero_hit) || $past(start_irq);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

  c_reload: cover property (@(posedge hclk) disable iff (!hresetn) do_count && at_zero);
  c_restart: cover property (@(posedge hclk) disable iff (!hresetn) start_trig && en_r);
  c_stop_edge: cover property (@(posedge hclk) disable iff (!hresetn) !en_r && eff_edge);
  c_start_irq: cover property (@(posedge hclk) disable iff (!hresetn) start_irq);
  c_zero_data: cover property (@(posedge hclk) disable iff (!hresetn) do_count && data_r == '0);

endmodule : tec_event_counter
`default_nettype wire

// ==== verif/tec_edge_src.sv ====
`timescale 1ns/100ps
`default_nettype none
module tec_edge_src (
  // Clock
  input wire logic hclk,
  // Count input drive
  output logic pin
);
  initial pin = 1'b0;
  // Gap of at least four cycles so the two-flop synchroniser never drops a level
  task automatic toggle(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge hclk);
      pin <= ~pin;
    end
  endtask : toggle
endmodule : tec_edge_src
`default_nettype wire

// ==== verif/timer_channel_event_counter_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tec_params.svh"
module timer_channel_event_counter_tb import tec_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pin;
  logic irq;
  logic [31:0] q;
  logic [31:0] d;
  logic [31:0] m;
  logic lvl = 1'b0;
  logic b;
  logic [3:0] mds [4] = '{`TEC_MD_INTERVAL, `TEC_MD_CAPTURE, `TEC_MD_CNTCAP, `TEC_MD_CAP_ONE};
  int n_fail = 0;
  int total_checks = 0;
  int irq_n = 0;
  int ne;
  int k;
  int e;

  always #25 hclk = ~hclk;
  always @(posedge hclk) if (irq === 1'b1) irq_n <= irq_n + 1;

  tec_event_counter #(.CNT_W(32)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .count_input_pin(pin), .channel_interrupt(irq));
  tec_edge_src src (.hclk(hclk), .pin(pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Master waits on hready, never on a fixed latency
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
    if (n >= 50) n_fail++;
  endtask : bus

  task automatic rd(input logic [11:0] a);
    bus(a, 1'b0, 32'h0000_0000);
  endtask : rd

  function automatic logic eff(input tec_sel_t c, input logic l);
    return (c == 2'b10) || (c == 2'b01 && l) || (c == 2'b00 && !l);
  endfunction : eff

  function automatic logic [31:0] exp_cnt(input logic [31:0] dv, input int n, output int irqs);
    logic [31:0] c;
    c = dv;
    irqs = 0;
    repeat (n) if (c == 0) begin c = dv; irqs++; end else c--;
    return c;
  endfunction : exp_cnt

  // Latency settles within six cycles after the last toggle
  task automatic drive(input int n, input tec_sel_t c);
    ne = 0;
    repeat (n) begin
      src.toggle(1, $urandom_range(4, 10));
      lvl = ~lvl;
      if (eff(c, lvl)) ne++;
    end
    repeat (6) @(posedge hclk);
  endtask : drive

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  initial begin
    #2_000_000;
    n_fail++;
    end_sim;
  end

  initial begin
    void'($urandom(32'h2a2ba3dc));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a <= 'h40; a += 4) begin
      rd(a[11:0]);
      chk(q, 32'h0000_0000);
    end
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      // Capture-and-one-count mode always gets a cleared low mode bit
      b = i[0] && (i < 6);
      bus(`TEC_OFF_TRIG, 1'b1, 32'h0000_0002);
      bus(`TEC_OFF_MODE, 1'b1, {27'h0, mds[i/2], b});
      k = irq_n;
      bus(`TEC_OFF_TRIG, 1'b1, 32'h0000_0001);
      repeat (4) @(posedge hclk);
      chk(32'(irq_n - k), 32'(b));
    end
    $display("test start interrupt done");
    for (int c = 0; c < 4; c++) begin
      bus(`TEC_OFF_TRIG, 1'b1, 32'h0000_0002);
      m = {16'h0, 2'($urandom_range(0, 3)), 2'b01, 7'h00, `TEC_MD_EVENT, 1'b0};
      bus(`TEC_OFF_MODE, 1'b1, m);
      rd(`TEC_OFF_MODE);
      chk(q, m);
      bus(`TEC_OFF_EDGE, 1'b1, 32'(c));
      d = (c == 0) ? 32'h0000_0000 : 32'($urandom_range(1, 4));
      bus(`TEC_OFF_DATA, 1'b1, d);
      bus(`TEC_OFF_TRIG, 1'b1, 32'h0000_0001);
      rd(`TEC_OFF_STAT);
      chk(q, 32'h0000_0001);
      rd(`TEC_OFF_CNT);
      chk(q, d);
      k = irq_n;
      drive($urandom_range(3, 12), c[1:0]);
      rd(`TEC_OFF_CNT);
      chk(q, exp_cnt(d, ne, e));
      chk(32'(irq_n - k), 32'(e));
    end
    $display("test edge codes done");
    bus(`TEC_OFF_EDGE, 1'b1, 32'h0000_0001);
    bus(`TEC_OFF_DATA, 1'b1, 32'h0000_0005);
    bus(`TEC_OFF_TRIG, 1'b1, 32'h0000_0001);
    bus(`TEC_OFF_MODE, 1'b1, 32'h0000_0000);
    rd(`TEC_OFF_MODE);
    chk(q, m);
    bus(`TEC_OFF_DATA, 1'b1, 32'h0000_0009);
    drive(2, 2'b01);
    rd(`TEC_OFF_CNT);
    chk(q, 32'h0000_0004);
    bus(`TEC_OFF_TRIG, 1'b1, 32'h0000_0001);
    rd(`TEC_OFF_CNT);
    chk(q, 32'h0000_0009);
    drive(2, 2'b01);
    bus(`TEC_OFF_TRIG, 1'b1, 32'h0000_0002);
    rd(`TEC_OFF_STAT);
    chk(q, 32'h0000_0000);
    drive(4, 2'b01);
    rd(`TEC_OFF_CNT);
    chk(q, 32'h0000_0008);
    bus(`TEC_OFF_TRIG, 1'b1, 32'h0000_0001);
    rd(`TEC_OFF_CNT);
    chk(q, 32'h0000_0009);
    drive(2, 2'b01);
    rd(`TEC_OFF_CNT);
    chk(q, 32'h0000_0008);
    bus(`TEC_OFF_AUX, 1'b1, 32'h0000_0000);
    rd(`TEC_OFF_AUX);
    chk(q, 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0000_0000);
    chk({31'h0, hreadyout}, 32'h0000_0001);
    $display("test stop and restart done");
    end_sim;
  end
endmodule : timer_channel_event_counter_tb
`default_nettype wire
